// [design/ssx_params.svh]
// Constants of the subtract/swap/xor/direction datapath: register
// offsets, status bit positions and reset values.
// Assumes inclusion by bare name from the datapath.
`ifndef SSX_PARAMS_SVH
`define SSX_PARAMS_SVH

// Register port offsets
`define SSX_OFF_ACC 4'h0
`define SSX_OFF_STATUS 4'h1
`define SSX_OFF_DIR_A 4'h2
`define SSX_OFF_DIR_B 4'h3
`define SSX_OFF_DIR_C 4'h4
`define SSX_OFF_OPCOUNT 4'h5

// Status register bit positions
`define SSX_ST_CARRY 0
`define SSX_ST_HALF 1
`define SSX_ST_ZERO 2

// Direction-load operand values
`define SSX_DIR_SEL_A 7'h05
`define SSX_DIR_SEL_B 7'h06
`define SSX_DIR_SEL_C 7'h07

// Reset values
`define SSX_RST_ACC 8'h00
`define SSX_RST_DIR 8'hff
`define SSX_RST_RDATA 8'h00

`endif

// [design/ssx_pkg.sv]
// Types of the subtract/swap/xor/direction datapath.
// Assumes ssx_params.svh is on the include path.
package ssx_pkg;

    // Operations carried out by the datapath
    typedef enum logic [2:0] {
        SSX_OP_NONE = 3'h0,
        SSX_OP_SUB = 3'h1,
        SSX_OP_SUB_BORROW = 3'h2,
        SSX_OP_NIBBLE_EXCHANGE = 3'h3,
        SSX_OP_XOR_IMMEDIATE = 3'h4,
        SSX_OP_XOR_FILE = 3'h5,
        SSX_OP_DIRECTION_LOAD = 3'h6
    } ssx_op_t;

    // One instruction from the decoder
    typedef struct packed {
        logic valid;
        ssx_op_t op;
        logic [6:0] addr;
        logic dest;
        logic [7:0] lit;
    } ssx_req_t;

    // Whole state of the datapath
    typedef struct packed {
        logic [7:0] acc;
        logic carry;
        logic half_carry_flag;
        logic zero;
        logic [7:0] port_a_direction;
        logic [7:0] port_b_direction;
        logic [7:0] port_c_direction;
        logic f_we;
        logic [6:0] f_waddr;
        logic [7:0] f_wdata;
        logic done;
        logic [7:0] rdata;
        logic [7:0] op_count;
    } ssx_state_t;

endpackage

// [design/ssx_sub_unit.sv]
// Parameterised subtractor: a minus b minus borrow, with carry and
// half carry in the not-borrow sense.
// Purely combinational; the caller registers the results.
`timescale 1ns/10ps
`default_nettype none

module ssx_sub_unit #(
    parameter int WIDTH = 8,
    parameter int HALF = 4
) (
    input wire logic [WIDTH-1:0] a_i,
    input wire logic [WIDTH-1:0] b_i,
    input wire logic no_borrow_i,
    output logic [WIDTH-1:0] diff_o,
    output logic carry_o,
    output logic half_o
);

    logic [WIDTH:0] full_sum;
    logic [HALF:0] low_sum;

    // Adding the inverse plus one keeps carry as not-borrow
    assign full_sum = {1'b0, a_i} + {1'b0, ~b_i} + {{WIDTH{1'b0}}, no_borrow_i};
    assign low_sum = {1'b0, a_i[HALF-1:0]} + {1'b0, ~b_i[HALF-1:0]} + {{HALF{1'b0}}, no_borrow_i};
    assign diff_o = full_sum[WIDTH-1:0];
    assign carry_o = full_sum[WIDTH];
    assign half_o = low_sum[HALF];

endmodule // ssx_sub_unit

`default_nettype wire

// [design/ssx_alu.sv]
// Execution datapath for subtract, nibble exchange, xor and
// direction-load operations of an 8-bit core, plus a small
// register port for software access to accumulator, flags and
// direction registers.
// Assumes the decoder presents one request per cycle together with
// the addressed file register value in the same cycle.
`timescale 1ns/10ps
`default_nettype none
`include "ssx_params.svh"

module ssx_alu
    import ssx_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int NIBBLE_W = 4
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire ssx_req_t req_i,
    input wire logic [7:0] f_rdata_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    output logic [7:0] acc_o,
    output logic carry_o,
    output logic half_carry_flag_o,
    output logic zero_o,
    output logic [7:0] port_a_direction_o,
    output logic [7:0] port_b_direction_o,
    output logic [7:0] port_c_direction_o,
    output logic f_we_o,
    output logic [6:0] f_waddr_o,
    output logic [7:0] f_wdata_o,
    output logic done_o
);

    ssx_state_t st_r;
    ssx_state_t st_nxt;

    logic [7:0] sub_diff;
    logic sub_carry;
    logic sub_half;
    logic sub_no_borrow;

    // Plain subtract has no borrow in; the borrow form uses carry as not-borrow
    assign sub_no_borrow = (req_i.op == SSX_OP_SUB_BORROW) ? st_r.carry : 1'b1;

    // One shared subtractor serves both subtract forms
    ssx_sub_unit #(
        .WIDTH(DATA_W),
        .HALF(NIBBLE_W)
    ) u_sub (
        .a_i(f_rdata_i),
        .b_i(st_r.acc),
        .no_borrow_i(sub_no_borrow),
        .diff_o(sub_diff),
        .carry_o(sub_carry),
        .half_o(sub_half)
    );

    // Next state: register port first, then the operation, so an
    // operation in the same cycle overrides a software write to the
    // same field; software cannot race the instruction stream.
    always_comb begin
        logic [7:0] res;
        logic has_res;
        res = 8'h00;
        has_res = 1'b0;
        st_nxt = st_r;
        st_nxt.f_we = 1'b0;
        st_nxt.done = 1'b0;
        st_nxt.rdata = `SSX_RST_RDATA;

        // Reads return the state before this cycle's updates
        if (reg_re_i) begin
            if (reg_addr_i == `SSX_OFF_ACC) begin
                st_nxt.rdata = st_r.acc;
            end else if (reg_addr_i == `SSX_OFF_STATUS) begin
                st_nxt.rdata = {5'h00, st_r.zero, st_r.half_carry_flag, st_r.carry};
            end else if (reg_addr_i == `SSX_OFF_DIR_A) begin
                st_nxt.rdata = st_r.port_a_direction;
            end else if (reg_addr_i == `SSX_OFF_DIR_B) begin
                st_nxt.rdata = st_r.port_b_direction;
            end else if (reg_addr_i == `SSX_OFF_DIR_C) begin
                st_nxt.rdata = st_r.port_c_direction;
            end else if (reg_addr_i == `SSX_OFF_OPCOUNT) begin
                st_nxt.rdata = st_r.op_count;
            end else begin
                st_nxt.rdata = 8'h00; // Unmapped reads as zero
            end
        end

        // Software writes; unmapped and read-only offsets are ignored
        if (reg_we_i) begin
            if (reg_addr_i == `SSX_OFF_ACC) begin
                st_nxt.acc = reg_wdata_i;
            end else if (reg_addr_i == `SSX_OFF_STATUS) begin
                st_nxt.carry = reg_wdata_i[`SSX_ST_CARRY];
                st_nxt.half_carry_flag = reg_wdata_i[`SSX_ST_HALF];
                st_nxt.zero = reg_wdata_i[`SSX_ST_ZERO];
            end else if (reg_addr_i == `SSX_OFF_DIR_A) begin
                st_nxt.port_a_direction = reg_wdata_i;
            end else if (reg_addr_i == `SSX_OFF_DIR_B) begin
                st_nxt.port_b_direction = reg_wdata_i;
            end else if (reg_addr_i == `SSX_OFF_DIR_C) begin
                st_nxt.port_c_direction = reg_wdata_i;
            end
        end

        // Operation: everything commits at the end of this one cycle
        if (req_i.valid && req_i.op != SSX_OP_NONE) begin
            st_nxt.done = 1'b1;
            st_nxt.op_count = st_r.op_count + 8'h01;
            case (req_i.op)
                SSX_OP_SUB, SSX_OP_SUB_BORROW: begin
                    res = sub_diff;
                    has_res = 1'b1;
                    st_nxt.carry = sub_carry;
                    st_nxt.half_carry_flag = sub_half;
                    st_nxt.zero = (sub_diff == 8'h00);
                end
                SSX_OP_NIBBLE_EXCHANGE: begin
                    res = {f_rdata_i[3:0], f_rdata_i[7:4]};
                    has_res = 1'b1;
                end
                SSX_OP_XOR_IMMEDIATE: begin
                    st_nxt.acc = st_r.acc ^ req_i.lit;
                    st_nxt.zero = ((st_r.acc ^ req_i.lit) == 8'h00);
                end
                SSX_OP_XOR_FILE: begin
                    res = st_r.acc ^ f_rdata_i;
                    has_res = 1'b1;
                    st_nxt.zero = ((st_r.acc ^ f_rdata_i) == 8'h00);
                end
                SSX_OP_DIRECTION_LOAD: begin
                    // Other operands have no target and are dropped
                    if (req_i.addr == `SSX_DIR_SEL_A) begin
                        st_nxt.port_a_direction = st_r.acc;
                    end else if (req_i.addr == `SSX_DIR_SEL_B) begin
                        st_nxt.port_b_direction = st_r.acc;
                    end else if (req_i.addr == `SSX_DIR_SEL_C) begin
                        st_nxt.port_c_direction = st_r.acc;
                    end
                end
                default: begin
                    st_nxt.done = 1'b0;
                    st_nxt.op_count = st_r.op_count; // Refused codes are not counted
                end
            endcase

            // Destination select shared by the file-operand forms
            if (has_res) begin
                if (req_i.dest) begin
                    st_nxt.f_we = 1'b1;
                    st_nxt.f_waddr = req_i.addr;
                    st_nxt.f_wdata = res;
                end else begin
                    st_nxt.acc = res;
                end
            end
        end
    end

    // Single register stage for the whole state
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_r <= '0;
            st_r.acc <= `SSX_RST_ACC;
            st_r.port_a_direction <= `SSX_RST_DIR;
            st_r.port_b_direction <= `SSX_RST_DIR;
            st_r.port_c_direction <= `SSX_RST_DIR;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state flops
    assign reg_rdata_o = st_r.rdata;
    assign acc_o = st_r.acc;
    assign carry_o = st_r.carry;
    assign half_carry_flag_o = st_r.half_carry_flag;
    assign zero_o = st_r.zero;
    assign port_a_direction_o = st_r.port_a_direction;
    assign port_b_direction_o = st_r.port_b_direction;
    assign port_c_direction_o = st_r.port_c_direction;
    assign f_we_o = st_r.f_we;
    assign f_waddr_o = st_r.f_waddr;
    assign f_wdata_o = st_r.f_wdata;
    assign done_o = st_r.done;

    // Plain subtract into the accumulator
    a_sub_acc_diff: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_SUB && !req_i.dest)
        |=> (acc_o == 8'($past(f_rdata_i) - $past(acc_o)) && !f_we_o))
        else $error("subtract result not in accumulator");

    // Carry and half carry follow the comparisons
    a_sub_flags: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_SUB)
        |=> (carry_o == ($past(acc_o) <= $past(f_rdata_i))
            && half_carry_flag_o == ($past(acc_o[3:0]) <= $past(f_rdata_i[3:0]))))
        else $error("subtract flags wrong");

    // Borrow subtract takes away the inverted carry
    a_subb_diff: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_SUB_BORROW && !req_i.dest)
        |=> (acc_o == 8'($past(f_rdata_i) - $past(acc_o) - {7'h00, !$past(carry_o)})))
        else $error("borrow subtract result wrong");

    // Borrow subtract into the file register
    a_subb_file: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_SUB_BORROW && req_i.dest)
        |=> (f_we_o && f_waddr_o == $past(req_i.addr) && $stable(acc_o)
            && zero_o == (f_wdata_o == 8'h00)))
        else $error("borrow subtract file write wrong");

    // Plain subtract back into the source register
    a_sub_file: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_SUB && req_i.dest && !reg_we_i)
        |=> (f_we_o && f_wdata_o == 8'($past(f_rdata_i) - $past(acc_o)) && $stable(acc_o)))
        else $error("subtract file write wrong");

    // Nibble exchange leaves every flag alone
    a_swap_flags: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_NIBBLE_EXCHANGE && !reg_we_i)
        |=> ($stable(carry_o) && $stable(half_carry_flag_o) && $stable(zero_o)))
        else $error("nibble exchange changed a flag");

    // Nibble exchange to the file it was read from
    a_swap_file: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_NIBBLE_EXCHANGE && req_i.dest)
        |=> (f_we_o && f_waddr_o == $past(req_i.addr)
            && f_wdata_o == {$past(f_rdata_i[3:0]), $past(f_rdata_i[7:4])}))
        else $error("nibble exchange write wrong");

    // Immediate xor changes accumulator and zero only
    a_xorl_acc: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_XOR_IMMEDIATE && !reg_we_i)
        |=> (acc_o == ($past(acc_o) ^ $past(req_i.lit)) && zero_o == (acc_o == 8'h00)
            && $stable(carry_o) && !f_we_o))
        else $error("immediate xor wrong");

    // File xor sets zero from the result it routes
    a_xorf_zero: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_XOR_FILE && !reg_we_i)
        |=> (zero_o == ($past(acc_o) == $past(f_rdata_i)) && $stable(half_carry_flag_o)))
        else $error("file xor zero wrong");

    // Direction load picks the port from the operand
    a_dir_load: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_DIRECTION_LOAD && req_i.addr == `SSX_DIR_SEL_B)
        |=> (port_b_direction_o == $past(acc_o) && $stable(port_a_direction_o)
            && $stable(zero_o)))
        else $error("direction load wrong");

    // One cycle per operation; no write without a request before it
    a_one_cycle: assert property (@(posedge clk_i) disable iff (srst_i)
        (f_we_o || done_o) |-> ($past(req_i.valid) && $past(req_i.op) != SSX_OP_NONE))
        else $error("write or done without request");

    // Borrow subtract flags include the borrow-in term
    a_subb_flags: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_SUB_BORROW)
        |=> (carry_o == ({1'b0, $past(f_rdata_i)} >= {1'b0, $past(acc_o)} + {8'h00, !$past(carry_o)})
            && half_carry_flag_o
            == ({1'b0, $past(f_rdata_i[3:0])} >= {1'b0, $past(acc_o[3:0])} + {4'h0, !$past(carry_o)})))
        else $error("borrow subtract flags wrong");

    // Borrow subtract written back carries the same difference
    a_subb_wdata: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_SUB_BORROW && req_i.dest)
        |=> (f_wdata_o == 8'($past(f_rdata_i) - $past(acc_o) - {7'h00, !$past(carry_o)})))
        else $error("borrow subtract file data wrong");

    // Zero follows the difference routed to the accumulator
    a_sub_zero: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_SUB && !req_i.dest)
        |=> (zero_o == (acc_o == 8'h00)))
        else $error("subtract zero flag wrong");

    // Nibble exchange into the accumulator writes no file
    a_swap_acc: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_NIBBLE_EXCHANGE && !req_i.dest)
        |=> (acc_o == {$past(f_rdata_i[3:0]), $past(f_rdata_i[7:4])} && !f_we_o))
        else $error("nibble exchange accumulator wrong");

    // File xor back into the file leaves the accumulator alone
    a_xorf_file: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_XOR_FILE && req_i.dest && !reg_we_i)
        |=> (f_we_o && f_waddr_o == $past(req_i.addr)
            && f_wdata_o == ($past(acc_o) ^ $past(f_rdata_i)) && $stable(acc_o)))
        else $error("file xor file write wrong");

    // File xor into the accumulator
    a_xorf_acc: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_XOR_FILE && !req_i.dest)
        |=> (acc_o == ($past(acc_o) ^ $past(f_rdata_i)) && !f_we_o))
        else $error("file xor accumulator wrong");

    // Operand 5 loads port A only and leaves the flags
    a_dir_port_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_DIRECTION_LOAD && req_i.addr == `SSX_DIR_SEL_A && !reg_we_i)
        |=> (port_a_direction_o == $past(acc_o) && $stable(port_b_direction_o)
            && $stable(port_c_direction_o) && $stable(carry_o) && !f_we_o))
        else $error("direction load port A wrong");

    // Operand 7 loads port C only and leaves the flags
    a_dir_port_c: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == SSX_OP_DIRECTION_LOAD && req_i.addr == `SSX_DIR_SEL_C && !reg_we_i)
        |=> (port_c_direction_o == $past(acc_o) && $stable(port_a_direction_o)
            && $stable(port_b_direction_o) && $stable(half_carry_flag_o) && !f_we_o))
        else $error("direction load port C wrong");

    // A code outside the operation set is dropped without a pulse
    a_refused_op: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op == 3'h7 && !reg_we_i)
        |=> (!done_o && !f_we_o && $stable(acc_o) && $stable(port_a_direction_o)))
        else $error("refused code had an effect");

    // Every accepted operation pulses done in the next cycle
    a_done_pulse: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.op != SSX_OP_NONE && req_i.op != 3'h7)
        |=> done_o)
        else $error("operation without done");

    // No request, no pulse: done and file write last one cycle only
    a_idle_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
        !req_i.valid |=> (!done_o && !f_we_o))
        else $error("pulse without request");

endmodule // ssx_alu

`default_nettype wire

// [testbench/ssx_file_mem.sv]
// File register memory seen from the datapath: 128 bytes, one read port
// that follows the request address, one write port from the datapath.
// Assumes the request and the file write come from ssx_alu on clk_i.
`timescale 1ns/10ps
`default_nettype none
module ssx_file_mem
    import ssx_pkg::*;
(
    input wire logic clk_i,
    input wire ssx_req_t req_i,
    input wire logic f_we_i,
    input wire logic [6:0] f_waddr_i,
    input wire logic [7:0] f_wdata_i,
    output logic [7:0] f_rdata_o
);
    logic [7:0] mem [128];
    logic [7:0] val;
    // Fixed contents so the bench can copy them as its shadow
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i * 37 + 5);
        end
    end
    // Write port, committed at the edge after the datapath asks
    always @(posedge clk_i) begin
        if (f_we_i) begin
            mem[f_waddr_i] <= f_wdata_i;
        end
    end
    // Forward a write still in flight; an idle port shows junk, not stale data
    always_comb begin
        val = (f_we_i && f_waddr_i == req_i.addr) ? f_wdata_i : mem[req_i.addr];
        f_rdata_o = req_i.valid ? val : ~val;
    end
endmodule // ssx_file_mem
`default_nettype wire

// [testbench/ssx_alu_bench.sv]
// Self-checking bench for ssx_alu: register port and operation tasks
// checked against a reference model kept here.
// Assumes ssx_pkg and the file memory model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module ssx_alu_bench
    import ssx_pkg::*;
;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    ssx_req_t req = '0;
    logic [3:0] ra = 4'h0;
    logic [7:0] rw = 8'h00;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [7:0] f_rdata, rd, acc, da, db, dc, fwd;
    logic c, h, z, fwe, done;
    logic [6:0] fwa;
    int n_errors = 0;
    int samples_checked = 0;
    // Reference model state
    logic [7:0] m_acc = 8'h00, m_da = 8'hff, m_db = 8'hff, m_dc = 8'hff, m_cnt = 8'h00;
    logic m_c = 1'b0, m_h = 1'b0, m_z = 1'b0;
    logic [7:0] sm [128];

    always #20 clk_i = ~clk_i;

    ssx_alu u_dut (.clk_i(clk_i), .srst_i(srst_i), .req_i(req), .f_rdata_i(f_rdata),
        .reg_addr_i(ra), .reg_wdata_i(rw), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rd),
        .acc_o(acc), .carry_o(c), .half_carry_flag_o(h), .zero_o(z), .port_a_direction_o(da),
        .port_b_direction_o(db), .port_c_direction_o(dc), .f_we_o(fwe), .f_waddr_o(fwa),
        .f_wdata_o(fwd), .done_o(done));
    ssx_file_mem u_mem (.clk_i(clk_i), .req_i(req), .f_we_i(fwe), .f_waddr_i(fwa),
        .f_wdata_i(fwd), .f_rdata_o(f_rdata));

    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Register write; a spare cycle keeps strobes from being set twice at once
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        we <= 1'b1;
        ra <= a;
        rw <= d;
        case (a)
            4'h0: m_acc = d;
            4'h1: {m_z, m_h, m_c} = d[2:0];
            4'h2: m_da = d;
            4'h3: m_db = d;
            4'h4: m_dc = d;
            default: ;
        endcase
        @(posedge clk_i);
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    // Read data stand in the cycle after the strobe only
    task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
        re <= 1'b1;
        ra <= a;
        @(posedge clk_i);
        re <= 1'b0;
        @(negedge clk_i);
        chk(40'(rd), 40'(e));
        @(negedge clk_i);
        chk(40'(rd), 40'h0);
        @(posedge clk_i);
    endtask

    task automatic rd_all();
        reg_rd(4'h0, m_acc);
        reg_rd(4'h1, {5'h00, m_z, m_h, m_c});
        reg_rd(4'h2, m_da);
        reg_rd(4'h3, m_db);
        reg_rd(4'h4, m_dc);
        reg_rd(4'h5, m_cnt);
        reg_rd(4'hf, 8'h00);
    endtask

    // One operation; keep leaves valid up so the next call follows back to back
    task automatic do_op(input ssx_op_t op, input logic [6:0] a, input logic d, input logic [7:0] k, input bit keep);
        logic [7:0] f, r;
        logic [8:0] t;
        logic [4:0] t5;
        logic bi, wf, dn;
        logic [39:0] ev;
        f = sm[a];
        bi = (op == SSX_OP_SUB_BORROW) ? !m_c : 1'b0;
        t = {1'b0, f} - {1'b0, m_acc} - 9'(bi);
        t5 = {1'b0, f[3:0]} - {1'b0, m_acc[3:0]} - 5'(bi);
        r = t[7:0];
        wf = 1'b0;
        dn = op != SSX_OP_NONE && op <= SSX_OP_DIRECTION_LOAD;
        case (op)
            SSX_OP_SUB, SSX_OP_SUB_BORROW: begin
                m_c = !t[8];
                m_h = !t5[4];
                wf = d;
            end
            SSX_OP_NIBBLE_EXCHANGE: begin
                r = {f[3:0], f[7:4]};
                wf = d;
            end
            SSX_OP_XOR_IMMEDIATE: r = m_acc ^ k;
            SSX_OP_XOR_FILE: begin
                r = m_acc ^ f;
                wf = d;
            end
            SSX_OP_DIRECTION_LOAD: begin
                if (a == 7'h05) m_da = m_acc;
                if (a == 7'h06) m_db = m_acc;
                if (a == 7'h07) m_dc = m_acc;
            end
            default: ;
        endcase
        if (op != SSX_OP_NONE && op <= SSX_OP_XOR_FILE) begin
            if (op != SSX_OP_NIBBLE_EXCHANGE) m_z = (r == 8'h00);
            if (wf) sm[a] = r;
            else m_acc = r;
        end
        if (dn) m_cnt++;
        ev = 40'({dn, wf, m_acc, m_c, m_h, m_z, m_da, m_db, m_dc});
        req <= '{valid: 1'b1, op: op, addr: a, dest: d, lit: k};
        @(posedge clk_i);
        if (!keep) begin
            req.valid <= 1'b0;
            @(negedge clk_i);
            chk(40'({done, fwe, acc, c, h, z, da, db, dc}), ev);
            if (wf) chk(40'({fwa, fwd}), 40'({a, r}));
            @(posedge clk_i);
        end
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        sm = u_mem.mem;
        rd_all();
        // Both subtracts around W equal to f, carry in both states
        for (int o = 1; o < 3; o++) begin
            for (int k = 0; k < 6; k++) begin
                reg_wr(4'h1, 8'(k % 2));
                reg_wr(4'h0, sm[7'h7f - 7'(k * 25)] + 8'(k / 2) - 8'h01);
                do_op(ssx_op_t'(o), 7'h7f - 7'(k * 25), k[2] ^ k[0], 8'h00, 1'b0);
            end
        end
        // Nibble exchange and xor must leave the other flags alone
        for (int d = 0; d < 2; d++) begin
            reg_wr(4'h1, d ? 8'h07 : 8'h00);
            do_op(SSX_OP_NIBBLE_EXCHANGE, 7'(16 + d), d[0], 8'h00, 1'b0);
            reg_wr(4'h1, 8'h03);
            reg_wr(4'h0, sm[7'(32 + d)]);
            do_op(SSX_OP_XOR_FILE, 7'(32 + d), d[0], 8'h00, 1'b0);
            do_op(SSX_OP_XOR_FILE, 7'(40 + d), d[0], 8'h00, 1'b0);
            do_op(SSX_OP_XOR_IMMEDIATE, 7'h00, 1'b0, m_acc, 1'b0);
            do_op(SSX_OP_XOR_IMMEDIATE, 7'h00, 1'b0, 8'hc3, 1'b0);
        end
        // Direction load with each legal operand only
        for (int s = 5; s < 8; s++) begin
            reg_wr(4'h0, 8'(s * 17));
            do_op(SSX_OP_DIRECTION_LOAD, 7'(s), 1'b0, 8'h00, 1'b0);
        end
        // Refused codes: no pulse, no count, no register change
        do_op(ssx_op_t'(3'h7), 7'h05, 1'b0, 8'h00, 1'b0);
        do_op(SSX_OP_NONE, 7'h06, 1'b0, 8'h00, 1'b0);
        // Back to back: each op sees the previous result, file write forwarded
        do_op(SSX_OP_XOR_IMMEDIATE, 7'h00, 1'b0, 8'h5a, 1'b1);
        do_op(SSX_OP_SUB_BORROW, 7'h40, 1'b0, 8'h00, 1'b1);
        do_op(SSX_OP_NIBBLE_EXCHANGE, 7'h40, 1'b1, 8'h00, 1'b1);
        do_op(SSX_OP_XOR_FILE, 7'h40, 1'b1, 8'h00, 1'b1);
        do_op(SSX_OP_DIRECTION_LOAD, 7'h06, 1'b0, 8'h00, 1'b0);
        // Read-only and unmapped writes must change nothing
        reg_wr(4'h5, 8'h77);
        reg_wr(4'h9, 8'h12);
        rd_all();
        // Every file write, back to back ones included, must have landed
        for (int i = 0; i < 128; i++) begin
            chk(40'(u_mem.mem[i]), 40'(sm[i]));
        end
        // A reset in mid-run brings back every reset value
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        {m_acc, m_da, m_db, m_dc, m_cnt} = {8'h00, 8'hff, 8'hff, 8'hff, 8'h00};
        {m_c, m_h, m_z} = 3'h0;
        rd_all();
        final_report();
    end

    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        final_report();
    end
endmodule // ssx_alu_bench
`default_nettype wire
